/* File: rtl/wcc_defs.svh */
// Register offsets, field positions, reset values and timing for the block
`ifndef WCC_DEFS_SVH
`define WCC_DEFS_SVH

`define WCC_ADDR_W 6
`define WCC_DATA_W 24
`define WCC_OFF_WET_UPPER 6'h1e
`define WCC_OFF_PULSE_CFG 6'h1f
`define WCC_OFF_PULSE_EN 6'h20
`define WCC_RESET_VAL 24'h00_0000
`define WCC_UPPER_RSVD_BIT 23
`define WCC_SINK_DIS_BIT 22
`define WCC_SRC_DIS_BIT 21
`define WCC_IN23_LSB 18
`define WCC_IN22_LSB 15
`define WCC_PTIME_MSB 6
`define WCC_PTIME_LSB 4
`define WCC_PGRP_MSB 3
`define WCC_CFG_USED_W 7
`define WCC_GROUP_SIZE 6
`define WCC_PULSE_STEP_US 64
`define WCC_CLK_PERIOD_NS 10
`define WCC_NS_PER_US 1000

`endif

/* File: rtl/wcc_pkg.sv */
// Types and the level decode shared by the configuration block
package wcc_pkg;

  // Wetting-current level delivered to one input
  typedef enum logic [2:0] {
    WCC_MA0,
    WCC_MA1,
    WCC_MA2,
    WCC_MA5,
    WCC_MA10,
    WCC_MA15
  } wcc_ma_type;

  typedef logic [2:0] wcc_code_type;

  function automatic wcc_ma_type wcc_decode(input wcc_code_type code);
    wcc_ma_type lvl;
    case (code)
      3'h0: lvl = WCC_MA0;
      3'h1: lvl = WCC_MA1;
      3'h2: lvl = WCC_MA2;
      3'h3: lvl = WCC_MA5;
      3'h4: lvl = WCC_MA10;
      default: lvl = WCC_MA15;
    endcase
    return lvl;
  endfunction

endpackage

/* File: rtl/wcc_scale_if.sv */
// Signals between the register bank and the wetting-current scaler
`timescale 1ns/1ps
interface wcc_scale_if;
  wcc_pkg::wcc_code_type [11:0] code;
  logic [11:0] sink_sel;
  logic [11:0] closed;
  logic continuous;
  logic sink_dis;
  logic src_dis;
  wcc_pkg::wcc_ma_type [11:0] level;

  modport regs (output code, sink_sel, closed, continuous, sink_dis,
                src_dis, input level);
  modport scaler (input code, sink_sel, closed, continuous, sink_dis,
                  src_dis, output level);
endinterface

/* File: rtl/wcc_wet_scale.sv */
// Decodes wetting-current codes of inputs 12..23 with continuous auto-scale
`timescale 1ns/1ps
module wcc_wet_scale (
  wcc_scale_if.scaler sif
);

  // ****************************************
  // Decode and scale
  // ****************************************
  genvar k;
  generate
    for (k = 0; k < 12; k++) begin : g_in
      wire wcc_pkg::wcc_ma_type raw_lvl = wcc_pkg::wcc_decode(sif.code[k]);
      wire high_lvl = (raw_lvl == wcc_pkg::WCC_MA10) ||
                      (raw_lvl == wcc_pkg::WCC_MA15);
      // Sink class is select bit 1, source class is 0
      wire class_dis = sif.sink_sel[k] ? sif.sink_dis : sif.src_dis;
      // In continuous mode a closed switch drops high settings to 2 mA unless disabled
      wire scale = sif.continuous && sif.closed[k] && high_lvl &&
                   !class_dis;
      assign sif.level[k] = scale ? wcc_pkg::WCC_MA2 : raw_lvl;
    end
  endgenerate

endmodule

/* File: rtl/wcc_config_regs.sv */
// Wetting-current and clean-current-pulse configuration register bank
`timescale 1ns/1ps
`include "wcc_defs.svh"
module wcc_config_regs #(
  parameter int PULSE_STEP_CYCLES =
    (`WCC_PULSE_STEP_US * `WCC_NS_PER_US) / `WCC_CLK_PERIOD_NS
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [`WCC_ADDR_W-1:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [`WCC_DATA_W-1:0] reg_wdata_i,
  output logic [`WCC_DATA_W-1:0] reg_rdata_o,
  input wire logic continuous_mode_i,
  input wire logic [11:0] sink_select_upper_i,
  input wire logic [11:0] switch_closed_upper_i,
  output wcc_pkg::wcc_ma_type [11:0] wet_level_upper_o,
  output logic [9:0] pulse_on_time_us_o,
  output logic [15:0] pulse_on_cycles_o,
  output logic [23:0] pulse_level_15ma_o,
  output logic [23:0] pulse_enable_o
);

  // ****************************************
  // Register decode
  // ****************************************
  logic [`WCC_DATA_W-2:0] wet_upper_q;
  logic [`WCC_CFG_USED_W-1:0] pulse_cfg_q;
  logic [23:0] pulse_en_q;
  wire hit_upper = reg_addr_i == `WCC_OFF_WET_UPPER;
  wire hit_cfg = reg_addr_i == `WCC_OFF_PULSE_CFG;
  wire hit_en = reg_addr_i == `WCC_OFF_PULSE_EN;
  wire wr_upper = reg_wr_i && hit_upper;
  wire wr_cfg = reg_wr_i && hit_cfg;
  wire wr_en = reg_wr_i && hit_en;

  // Reserved top bits are never stored, so they cannot read back
  wire [`WCC_DATA_W-1:0] upper_view = {1'b0, wet_upper_q};
  wire [`WCC_DATA_W-1:0] cfg_view =
    {{(`WCC_DATA_W-`WCC_CFG_USED_W){1'b0}}, pulse_cfg_q};
  wire [`WCC_DATA_W-1:0] rd_mux =
    hit_upper ? upper_view :
    hit_cfg ? cfg_view :
    hit_en ? pulse_en_q : `WCC_RESET_VAL;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wet_upper_q <= (`WCC_DATA_W-1)'(`WCC_RESET_VAL);
    end else if (wr_upper) begin
      wet_upper_q <= reg_wdata_i[`WCC_DATA_W-2:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_cfg_q <= `WCC_CFG_USED_W'(0);
    end else if (wr_cfg) begin
      pulse_cfg_q <= reg_wdata_i[`WCC_CFG_USED_W-1:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_en_q <= `WCC_RESET_VAL;
    end else if (wr_en) begin
      pulse_en_q <= reg_wdata_i;
    end
  end

  // Read data stays until the next read strobe; unmapped reads give zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `WCC_RESET_VAL;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // ****************************************
  // Field extraction
  // ****************************************
  // Pairs share a field; inputs 22 and 23 each own one
  function automatic int field_lsb(input int k);
    int lsb;
    lsb = (k / 2) * 3;
    if (k == 10) lsb = `WCC_IN22_LSB;
    if (k == 11) lsb = `WCC_IN23_LSB;
    return lsb;
  endfunction

  wcc_scale_if sif ();
  genvar k;
  generate
    for (k = 0; k < 12; k++) begin : g_fld
      assign sif.code[k] = wet_upper_q[field_lsb(k) +: 3];
    end
  endgenerate
  assign sif.sink_sel = sink_select_upper_i;
  assign sif.closed = switch_closed_upper_i;
  assign sif.continuous = continuous_mode_i;
  assign sif.sink_dis = wet_upper_q[`WCC_SINK_DIS_BIT];
  assign sif.src_dis = wet_upper_q[`WCC_SRC_DIS_BIT];

  wcc_wet_scale u_scale (
    .sif(sif)
  );

  // ****************************************
  // Pulse settings
  // ****************************************
  wire [2:0] ptime = pulse_cfg_q[`WCC_PTIME_MSB:`WCC_PTIME_LSB];
  wire [3:0] pgrp = pulse_cfg_q[`WCC_PGRP_MSB:0];
  wire [3:0] ptime_steps = {1'b0, ptime} + 4'h1;
  wire [9:0] ptime_us_d = 10'(ptime_steps * `WCC_PULSE_STEP_US);
  wire [15:0] pcycles_d = 16'(ptime_steps * PULSE_STEP_CYCLES);
  logic [23:0] plevel_d;
  always_comb begin
    for (int i = 0; i < 24; i++) begin
      plevel_d[i] = pgrp[i / `WCC_GROUP_SIZE];
    end
  end

  // Outputs registered so the analog side sees glitch-free levels
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wet_level_upper_o <= '{default: wcc_pkg::WCC_MA0};
      pulse_on_time_us_o <= 10'h000;
      pulse_on_cycles_o <= 16'h0000;
      pulse_level_15ma_o <= 24'h00_0000;
      pulse_enable_o <= 24'h00_0000;
    end else begin
      wet_level_upper_o <= sif.level;
      pulse_on_time_us_o <= ptime_us_d;
      pulse_on_cycles_o <= pcycles_d;
      pulse_level_15ma_o <= plevel_d;
      pulse_enable_o <= pulse_en_q;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  wire [2:0] code23 = wet_upper_q[`WCC_IN23_LSB +: 3];
  wire [2:0] code12 = wet_upper_q[2:0];
  wire hi12 = code12 >= 3'h4;
  wire [2:0] code20 = wet_upper_q[14:12];
  wire [2:0] code22 = wet_upper_q[`WCC_IN22_LSB +: 3];

  sequence s_cfg_write_then_read;
    wr_cfg ##1 (reg_rd_i && hit_cfg && !reg_wr_i);
  endsequence

  chk_upper_rsvd_zero: assert property (
    $past(reg_rd_i && hit_upper) |-> reg_rdata_o[23] == 1'b0)
    else $error("upper register reserved bit read nonzero");
  chk_cfg_readback: assert property (
    s_cfg_write_then_read |=> reg_rdata_o ==
      {17'h0_0000, $past(reg_wdata_i[6:0], 2)})
    else $error("pulse config readback mismatch");
  chk_cfg_rsvd_zero: assert property (
    $past(reg_rd_i && hit_cfg) |-> reg_rdata_o[23:7] == 17'h0_0000)
    else $error("pulse config reserved bits nonzero");
  chk_pulse_time_val: assert property (
    wr_cfg |-> ##2 pulse_on_time_us_o ==
      10'(($past(reg_wdata_i[6:4], 2) + 4'h1) * `WCC_PULSE_STEP_US))
    else $error("pulse time not (n+1)*64 us");
  chk_pulse_group_lvl: assert property (
    wr_cfg |-> ##2 (pulse_level_15ma_o[5:0] == {6{$past(reg_wdata_i[0], 2)}}
      && pulse_level_15ma_o[23:18] == {6{$past(reg_wdata_i[3], 2)}}))
    else $error("pulse group level wrong");
  chk_pulse_enable_out: assert property (
    wr_en |-> ##2 pulse_enable_o == $past(reg_wdata_i, 2))
    else $error("pulse enable not applied");
  chk_in23_decode: assert property (
    !continuous_mode_i |=> wet_level_upper_o[11] ==
      wcc_pkg::wcc_decode($past(code23)))
    else $error("input 23 level decode wrong");
  chk_sink_scale_2ma: assert property (
    (continuous_mode_i && switch_closed_upper_i[0] && sink_select_upper_i[0]
      && hi12 && !wet_upper_q[`WCC_SINK_DIS_BIT])
      |=> wet_level_upper_o[0] == wcc_pkg::WCC_MA2)
    else $error("sink input not scaled to 2 mA");
  chk_src_scale_off: assert property (
    (continuous_mode_i && switch_closed_upper_i[0] && !sink_select_upper_i[0]
      && wet_upper_q[`WCC_SRC_DIS_BIT])
      |=> wet_level_upper_o[0] == wcc_pkg::wcc_decode($past(code12)))
    else $error("source input scaled while disabled");
  chk_pulse_cycles_val: assert property (
    wr_cfg |-> ##2 pulse_on_cycles_o ==
      16'(($past(reg_wdata_i[6:4], 2) + 4'h1) * PULSE_STEP_CYCLES))
    else $error("pulse cycle count not (n+1) steps");
  chk_src_scale_2ma: assert property (
    (continuous_mode_i && switch_closed_upper_i[0] && !sink_select_upper_i[0]
      && hi12 && !wet_upper_q[`WCC_SRC_DIS_BIT])
      |=> wet_level_upper_o[0] == wcc_pkg::WCC_MA2)
    else $error("source input not scaled to 2 mA");
  chk_sink_scale_off: assert property (
    (continuous_mode_i && switch_closed_upper_i[0] && sink_select_upper_i[0]
      && wet_upper_q[`WCC_SINK_DIS_BIT])
      |=> wet_level_upper_o[0] == wcc_pkg::wcc_decode($past(code12)))
    else $error("sink input scaled while disabled");
  chk_in22_decode: assert property (
    !continuous_mode_i |=> wet_level_upper_o[10] ==
      wcc_pkg::wcc_decode($past(code22)))
    else $error("input 22 level decode wrong");
  chk_pair20_decode: assert property (
    !continuous_mode_i |=> (wet_level_upper_o[8] == wet_level_upper_o[9]
      && wet_level_upper_o[8] == wcc_pkg::wcc_decode($past(code20))))
    else $error("inputs 20 and 21 level decode wrong");

endmodule

/* File: bench/wetting_current_ccp_config_regs_test.sv */
// Self-checking bench for the wetting-current and pulse configuration bank
`timescale 1ns/1ps
module wetting_current_ccp_config_regs_test;
  // ****************************************
  // Signals and bench state
  // ****************************************
  // Short pulse step keeps the derived cycle count small in simulation
  localparam int STEP = 8;
  localparam int LIMIT = 5000;
  logic clk_i, rst_b_i, reg_wr_i, reg_rd_i, continuous_mode_i;
  logic [5:0] reg_addr_i;
  logic [23:0] reg_wdata_i, reg_rdata_o, pulse_level_15ma_o, pulse_enable_o;
  logic [11:0] sink_select_upper_i, switch_closed_upper_i;
  wcc_pkg::wcc_ma_type [11:0] wet_level_upper_o;
  logic [9:0] pulse_on_time_us_o;
  logic [15:0] pulse_on_cycles_o;
  logic [15:0] lfsr_q = 16'hfc61;
  logic [23:0] up_m, cfg_m, en_m, v, rb;
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;

  wcc_config_regs #(.PULSE_STEP_CYCLES(STEP)) dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .continuous_mode_i(continuous_mode_i),
    .sink_select_upper_i(sink_select_upper_i),
    .switch_closed_upper_i(switch_closed_upper_i),
    .wet_level_upper_o(wet_level_upper_o),
    .pulse_on_time_us_o(pulse_on_time_us_o),
    .pulse_on_cycles_o(pulse_on_cycles_o),
    .pulse_level_15ma_o(pulse_level_15ma_o), .pulse_enable_o(pulse_enable_o));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic rnd(output logic [23:0] r);
    lfsr_q = lfsr_next(lfsr_q);
    r[23:12] = lfsr_q[11:0];
    lfsr_q = lfsr_next(lfsr_q);
    r[11:0] = lfsr_q[11:0];
  endtask

  task automatic wrap_up();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Level the input should carry, worked out from the model registers
  function automatic int exp_lvl(int k);
    int c;
    c = (k < 10) ? int'(up_m[3*(k/2) +: 3]) :
        (k == 10) ? int'(up_m[17:15]) : int'(up_m[20:18]);
    if (c > 5) c = 5;
    if (continuous_mode_i && switch_closed_upper_i[k] && c >= 4 &&
        (sink_select_upper_i[k] ? !up_m[22] : !up_m[21])) c = 2;
    return c;
  endfunction

  task automatic cmp_lvl(int k);
    checks_done++;
    if (wet_level_upper_o[k] !== wcc_pkg::wcc_ma_type'(exp_lvl(k))) begin
      miscompares++;
      $display("unexpected at %0t: level of slot %0d", $time, k);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [5:0] a, output logic [23:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // Write then read the same register on the very next edge
  task automatic wr_rd(input logic [5:0] a, input logic [23:0] d,
                       output logic [23:0] q);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    #1 q = reg_rdata_o;
  endtask

  task automatic check_all();
    logic [23:0] g, e;
    rd(6'h1e, g); cmp(g, up_m);
    rd(6'h1f, g); cmp(g, cfg_m);
    rd(6'h20, g); cmp(g, en_m);
    rd(6'h3f, g); cmp(g, 24'h00_0000);
    cmp(24'(pulse_on_time_us_o), 24'((int'(cfg_m[6:4]) + 1) * 64));
    cmp(24'(pulse_on_cycles_o), 24'((int'(cfg_m[6:4]) + 1) * STEP));
    for (int i = 0; i < 24; i++) e[i] = cfg_m[i/6];
    cmp(pulse_level_15ma_o, e);
    cmp(pulse_enable_o, en_m);
    for (int k = 0; k < 12; k++) cmp_lvl(k);
  endtask

  // ****************************************
  // Watchdog and main sequence
  // ****************************************
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      $display("unexpected at %0t: run did not finish", $time);
      wrap_up();
    end
  end

  initial begin
    rst_b_i = 1'b0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    reg_addr_i = 6'h00;
    reg_wdata_i = 24'h00_0000;
    continuous_mode_i = 1'b0;
    sink_select_upper_i = 12'h000;
    switch_closed_upper_i = 12'h000;
    {up_m, cfg_m, en_m} = '0;
    repeat (12) @(posedge clk_i);
    rst_b_i <= 1'b1;
    check_all();
    for (int n = 0; n < 40; n++) begin
      // Second reset mid-run must clear everything again
      if (n == 20) begin
        @(posedge clk_i);
        rst_b_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_b_i <= 1'b1;
        {up_m, cfg_m, en_m} = '0;
        check_all();
      end
      rnd(v); wr(6'h1e, v); up_m = v & 24'h7f_ffff;
      rnd(v); wr_rd(6'h1f, v, rb); cfg_m = v & 24'h00_007f;
      cmp(rb, cfg_m);
      rnd(v); wr(6'h20, v); en_m = v;
      rnd(v); wr(6'h3f, v);
      rnd(v);
      @(posedge clk_i);
      continuous_mode_i <= v[0] | v[1];
      sink_select_upper_i <= v[13:2];
      switch_closed_upper_i <= v[23:12];
      check_all();
    end
    wrap_up();
  end
endmodule
